//--- logic/slp_ctrl.sv
/*
 * short-current detection, load-open sensing and power save / power down
 * control behind two 8-bit registers.
 * assumes a serial decoder that presents one-cycle read and write requests,
 * comparator levels already synchronous to clk, and FET control bits held
 * in another block that obeys the fet_clear pulse.
 */
`timescale 1ns/100ps

// How it works
// (RULE_01) short detector runs only while enabled
// (RULE_02) short event drives interrupt only when enabled
// (RULE_03) short flag sticky, write zero clears
// (RULE_04) short comparator bit read-only, zero when disabled
// (RULE_05) comparator rise starts delay capacitor charging
// (RULE_06) delay done sets flag, clears FETs
// (RULE_07) short ending early aborts, grounds capacitor
// (RULE_08) delay is 100 us per nF
// (RULE_09) load comparator runs only while enabled
// (RULE_10) load rise drives interrupt when enabled
// (RULE_11) host waits 1 ms before load irq
// (RULE_12) load flag sticky on rise, zero clears
// (RULE_13) load state read-only, zero when disabled
// (RULE_14) power save stops measurement and the load comparator; the short comparator keeps running
// (RULE_15) host re-enables comparators after power save
// (RULE_16) power down stops all, resets host
// (RULE_17) wake pin low defers power down
// (RULE_18) host checks wake pin before power down
// (RULE_19) host turns FETs off before power down
// (RULE_20) charger or wake pin ends power down
// (RULE_21) host waits supply before reinitialising
// (RULE_22) host rewrites FET bits after short
// (RULE_23) leaving power down clears writable bits
module slp_ctrl #(
   parameter int DELAY_CAP_NF = slp_pkg::DELAY_CAP_NF_DEFAULT,
   parameter int DELAY_CYCLES = slp_pkg::SHORT_DELAY_US_PER_NF * DELAY_CAP_NF
                                * (slp_pkg::CLK_HZ / 1_000_000)
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire slp_pkg::slp_req_t req,
   output logic [7:0] rdata,
   input wire logic short_comp_in,
   input wire logic load_comp_in,
   input wire logic charger_detect_in,
   input wire logic wake_pin_n,
   output logic irq_out_n,
   output logic host_clear_out_n,
   output logic delay_cap_charge,
   output logic fet_clear,
   output logic load_pulldown_en,
   output logic charger_pullup_en,
   output logic measure_en,
   output logic power_save_state
);
   localparam int CW = $clog2(DELAY_CYCLES + 1);

   if (DELAY_CYCLES < 2)
   begin : g_bad
      $error("DELAY_CYCLES must be at least 2");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   slp_pkg::slp_pwr_state_t state_q;
   logic short_detect_enable_q, short_irq_enable_q, short_irq_flag_q;
   logic load_comp_enable_q, load_irq_enable_q, load_irq_flag_q;
   logic power_save_req_q, power_off_req_q;
   logic short_comp_out_q, load_open_state_q, load_open_prev_q;
   logic [CW-1:0] dly_cnt_q;
   logic [7:0] rdata_q;
   logic irq_out_n_q, host_clear_out_n_q, delay_cap_charge_q, fet_clear_q;
   logic load_pulldown_q, charger_pullup_q, measure_en_q;
   logic wr_sense, wr_power, wake_exit, running, short_trip, load_rise;
   logic short_irq_enable_d, load_irq_enable_d;

   assign wr_sense = req.wr && req.addr == slp_pkg::SENSE_CTRL_ADDR && state_q != slp_pkg::ST_DOWN;
   assign wr_power = req.wr && req.addr == slp_pkg::POWER_CTRL_ADDR && state_q != slp_pkg::ST_DOWN;
   assign running = state_q != slp_pkg::ST_DOWN;
   assign wake_exit = state_q == slp_pkg::ST_DOWN && (charger_detect_in || !wake_pin_n);
   assign short_trip = short_comp_out_q && dly_cnt_q == CW'(DELAY_CYCLES - 1);
   assign load_rise = load_open_state_q && !load_open_prev_q;
   assign short_irq_enable_d = wr_sense ? req.wdata[slp_pkg::SHORT_IRQ_ENABLE_BIT]
                                        : short_irq_enable_q;
   assign load_irq_enable_d = wr_sense ? req.wdata[slp_pkg::LOAD_IRQ_ENABLE_BIT]
                                       : load_irq_enable_q;

   // ----------------------------------------------------------------
   // power state machine
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_q <= slp_pkg::ST_RUN;
      else
         case (state_q)
            slp_pkg::ST_RUN:
               if (power_off_req_q)
                  state_q <= wake_pin_n ? slp_pkg::ST_DOWN : slp_pkg::ST_DEFER; // RULE_17
            slp_pkg::ST_DEFER:
               if (!power_off_req_q)
                  state_q <= slp_pkg::ST_RUN;
               else if (wake_pin_n)
                  state_q <= slp_pkg::ST_DOWN; // RULE_17
            slp_pkg::ST_DOWN:
               if (wake_exit)
                  state_q <= slp_pkg::ST_RUN; // RULE_20
            default:
               state_q <= slp_pkg::ST_RUN;
         endcase
   end

   // ----------------------------------------------------------------
   // writable control bits
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst || wake_exit) // RULE_23
      begin
         short_detect_enable_q <= 1'b0;
         short_irq_enable_q <= 1'b0;
         load_comp_enable_q <= 1'b0;
         load_irq_enable_q <= 1'b0;
         power_save_req_q <= 1'b0;
         power_off_req_q <= 1'b0;
      end
      else
      begin
         if (wr_sense)
         begin
            short_detect_enable_q <= req.wdata[slp_pkg::SHORT_DETECT_ENABLE_BIT];
            short_irq_enable_q <= req.wdata[slp_pkg::SHORT_IRQ_ENABLE_BIT];
            load_comp_enable_q <= req.wdata[slp_pkg::LOAD_COMP_ENABLE_BIT];
            load_irq_enable_q <= req.wdata[slp_pkg::LOAD_IRQ_ENABLE_BIT];
         end
         if (wr_power)
         begin
            power_save_req_q <= req.wdata[slp_pkg::POWER_SAVE_REQ_BIT];
            power_off_req_q <= req.wdata[slp_pkg::POWER_OFF_REQ_BIT];
            // load comparator is left stopped after power save
            if (req.wdata[slp_pkg::POWER_SAVE_REQ_BIT] && !wr_sense)
               load_comp_enable_q <= 1'b0; // RULE_14
         end
      end
   end

   // ----------------------------------------------------------------
   // sticky flags: a hardware set beats a software clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst || wake_exit || !short_irq_enable_d)
         short_irq_flag_q <= 1'b0; // RULE_03
      else if (short_trip)
         short_irq_flag_q <= 1'b1; // RULE_06
      else if (wr_sense && !req.wdata[slp_pkg::SHORT_IRQ_FLAG_BIT])
         short_irq_flag_q <= 1'b0; // RULE_03
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || wake_exit || !load_irq_enable_d)
         load_irq_flag_q <= 1'b0; // RULE_12
      else if (load_rise)
         load_irq_flag_q <= 1'b1; // RULE_12
      else if (wr_sense && !req.wdata[slp_pkg::LOAD_IRQ_FLAG_BIT])
         load_irq_flag_q <= 1'b0; // RULE_12
   end

   // ----------------------------------------------------------------
   // short detection and delay timing
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         short_comp_out_q <= 1'b0;
      else
         short_comp_out_q <= short_detect_enable_q && running && short_comp_in; // RULE_01 RULE_04
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || !short_comp_out_q)
         dly_cnt_q <= '0; // RULE_07
      else if (dly_cnt_q != CW'(DELAY_CYCLES))
         dly_cnt_q <= dly_cnt_q + CW'(1); // RULE_05 RULE_08
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         delay_cap_charge_q <= 1'b0;
         fet_clear_q <= 1'b0;
      end
      else
      begin
         // charging holds only while a short persists and the delay is unfinished
         delay_cap_charge_q <= short_comp_in && short_detect_enable_q && running
                               && !(short_comp_out_q && dly_cnt_q >= CW'(DELAY_CYCLES - 1)); // RULE_05 RULE_07
         fet_clear_q <= short_trip; // RULE_06
      end
   end

   // ----------------------------------------------------------------
   // load-open comparator
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         load_open_state_q <= 1'b0;
         load_open_prev_q <= 1'b0;
      end
      else
      begin
         load_open_state_q <= load_comp_enable_q && !power_save_req_q && running
                              && load_comp_in; // RULE_09 RULE_13 RULE_14
         load_open_prev_q <= load_open_state_q;
      end
   end

   // ----------------------------------------------------------------
   // pin outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         irq_out_n_q <= 1'b1;
         host_clear_out_n_q <= 1'b1;
         load_pulldown_q <= 1'b0;
         charger_pullup_q <= 1'b0;
         measure_en_q <= 1'b0;
      end
      else
      begin
         irq_out_n_q <= !(short_irq_flag_q || load_irq_flag_q); // RULE_02 RULE_10
         host_clear_out_n_q <= running; // RULE_16
         charger_pullup_q <= !running; // RULE_16
         load_pulldown_q <= load_comp_enable_q && !power_save_req_q && running; // RULE_09
         measure_en_q <= !power_save_req_q && running; // RULE_14 RULE_16
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdata_q <= slp_pkg::REG_RESET;
      else if (req.rd)
      begin
         if (req.addr == slp_pkg::SENSE_CTRL_ADDR)
            rdata_q <= {short_detect_enable_q, short_irq_enable_q, short_irq_flag_q,
                        short_comp_out_q, load_comp_enable_q, load_irq_enable_q,
                        load_irq_flag_q, load_open_state_q};
         else if (req.addr == slp_pkg::POWER_CTRL_ADDR)
            rdata_q <= {!wake_pin_n, 2'h0, power_off_req_q, 3'h0, power_save_req_q};
         else
            rdata_q <= slp_pkg::UNMAPPED_READ;
      end
   end

   assign rdata = rdata_q;
   assign irq_out_n = irq_out_n_q;
   assign host_clear_out_n = host_clear_out_n_q;
   assign delay_cap_charge = delay_cap_charge_q;
   assign fet_clear = fet_clear_q;
   assign load_pulldown_en = load_pulldown_q;
   assign charger_pullup_en = charger_pullup_q;
   assign measure_en = measure_en_q;
   assign power_save_state = power_save_req_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic [CW-1:0] held_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst || !delay_cap_charge_q)
         held_q <= '0;
      else if (held_q != CW'(DELAY_CYCLES))
         held_q <= held_q + CW'(1);
   end
   sequence s_wake;
      state_q == slp_pkg::ST_DOWN && (charger_detect_in || !wake_pin_n);
   endsequence
   sequence s_off_req_wake_low;
      state_q == slp_pkg::ST_RUN && power_off_req_q && !wake_pin_n;
   endsequence
   property p_sc_off;
      !short_detect_enable_q |=> !short_comp_out_q;
   endproperty
   a_sc_off: assert property (p_sc_off) else $error("short comparator ran while disabled"); // RULE_01
   property p_irq_cause;
      $fell(irq_out_n_q) |-> $past(short_irq_flag_q || load_irq_flag_q);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without flag"); // RULE_02
   property p_sflag_forced;
      !short_irq_enable_q |-> !short_irq_flag_q;
   endproperty
   a_sflag_forced: assert property (p_sflag_forced) else $error("short flag set while disabled"); // RULE_03
   property p_trip_time;
      fet_clear_q |-> $past(held_q) == CW'(DELAY_CYCLES - 1) ##1 !fet_clear_q;
   endproperty
   a_trip_time: assert property (p_trip_time) else $error("short delay length wrong"); // RULE_08
   property p_abort;
      $fell(short_comp_out_q) |=> !delay_cap_charge_q && !fet_clear_q;
   endproperty
   a_abort: assert property (p_abort) else $error("delay not aborted"); // RULE_07
   property p_lflag_set;
      load_rise && load_irq_enable_d |=> load_irq_flag_q;
   endproperty
   a_lflag_set: assert property (p_lflag_set) else $error("load flag missed"); // RULE_12
   property p_defer;
      s_off_req_wake_low |=> state_q == slp_pkg::ST_DEFER;
   endproperty
   a_defer: assert property (p_defer) else $error("power down not deferred"); // RULE_17
   property p_down_pins;
      state_q == slp_pkg::ST_DOWN |=> !host_clear_out_n_q && charger_pullup_q && !measure_en_q;
   endproperty
   a_down_pins: assert property (p_down_pins) else $error("power down pins wrong"); // RULE_16
   property p_wake;
      s_wake |=> state_q == slp_pkg::ST_RUN && !power_off_req_q && !short_detect_enable_q
                 ##1 host_clear_out_n_q;
   endproperty
   a_wake: assert property (p_wake) else $error("wake from power down failed"); // RULE_20
   property p_psv;
      power_save_req_q |=> !measure_en_q && !load_open_state_q;
   endproperty
   a_psv: assert property (p_psv) else $error("power save left sensing on"); // RULE_14
endmodule

//--- logic/slp_pkg.sv
/*
 * package for the short, load and power state control block: register
 * offsets, bit positions, reset values, power states, timing figures and
 * the register access carrier.
 * assumes a serial front end that turns host frames into single-cycle
 * register requests.
 */
package slp_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] SENSE_CTRL_ADDR = 8'h05;
   localparam logic [7:0] POWER_CTRL_ADDR = 8'h06;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ----------------------------------------------------------------
   // short_and_load_sense_ctrl fields
   // ----------------------------------------------------------------
   localparam int SHORT_DETECT_ENABLE_BIT = 7;
   localparam int SHORT_IRQ_ENABLE_BIT = 6;
   localparam int SHORT_IRQ_FLAG_BIT = 5;
   localparam int SHORT_COMP_OUT_BIT = 4;
   localparam int LOAD_COMP_ENABLE_BIT = 3;
   localparam int LOAD_IRQ_ENABLE_BIT = 2;
   localparam int LOAD_IRQ_FLAG_BIT = 1;
   localparam int LOAD_OPEN_STATE_BIT = 0;

   // ----------------------------------------------------------------
   // power_state_ctrl fields
   // ----------------------------------------------------------------
   localparam int WAKE_PIN_LEVEL_BIT = 7;
   localparam int POWER_OFF_REQ_BIT = 4;
   localparam int POWER_SAVE_REQ_BIT = 0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int SHORT_DELAY_US_PER_NF = 100;
   localparam int DELAY_CAP_NF_DEFAULT = 1;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_DEFER = 2'b01,
      ST_DOWN = 2'b11
   } slp_pwr_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } slp_req_t;
endpackage

//--- test/slp_host_model.sv
/*
 * host microcontroller model: single-cycle register requests, read-back,
 * and the host's etiquette around load interrupts and power down.
 * assumes slp_ctrl takes a request on the rising edge and answers rdata
 * within two edges.
 */
`timescale 1ns/100ps
module slp_host_model #(
   parameter int SETTLE_CYCLES = 10000
) (
   input wire logic clk,
   input wire logic [7:0] rdata,
   input wire logic host_clear_out_n,
   output slp_pkg::slp_req_t req
);
   initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'hff};

   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      // idle fields flip so a stale value never looks live
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      access(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      access(1'b0, a, 8'h00);
      @(negedge clk);
      d = rdata;
   endtask

   // enables the load comparator, lets it settle, then its interrupt
   task automatic enable_load_irq();
      wr(slp_pkg::SENSE_CTRL_ADDR, 8'h08);
      repeat (SETTLE_CYCLES) @(negedge clk);
      wr(slp_pkg::SENSE_CTRL_ADDR, 8'h0c);
   endtask

   // FETs are off and charger gone before this is called
   task automatic power_down(output logic [7:0] st);
      rd(slp_pkg::POWER_CTRL_ADDR, st);
      if (st[slp_pkg::WAKE_PIN_LEVEL_BIT] === 1'b0)
      begin
         wr(slp_pkg::POWER_CTRL_ADDR, 8'h10);
      end
   endtask

   task automatic wait_release(output int n);
      n = 0;
      while (host_clear_out_n !== 1'b1 && n < 50)
      begin
         @(negedge clk);
         n++;
      end
      repeat (4) @(negedge clk);
   endtask
endmodule

//--- test/tb_short_load_power_ctrl.sv
/*
 * self-checking bench for slp_ctrl: register access, short delay, load
 * sensing, power save and power down.
 * assumes slp_pkg and the host model; inputs change on falling edges.
 */
`timescale 1ns/100ps
module tb_short_load_power_ctrl;
   localparam int DLY = 8;
   localparam logic [7:0] SA = slp_pkg::SENSE_CTRL_ADDR;
   localparam logic [7:0] PA = slp_pkg::POWER_CTRL_ADDR;
   logic clk, sys_rst, short_comp_in, load_comp_in, charger_detect_in, wake_pin_n;
   slp_pkg::slp_req_t req;
   logic [7:0] rdata, v;
   logic irq_out_n, host_clear_out_n, delay_cap_charge, fet_clear;
   logic load_pulldown_en, charger_pullup_en, measure_en, power_save_state;
   int n_mismatch = 0;
   int checked = 0;
   int n_fet = 0;
   int n, f0;

   slp_ctrl #(.DELAY_CYCLES(DLY)) dut (.clk(clk), .sys_rst(sys_rst), .req(req),
      .rdata(rdata), .short_comp_in(short_comp_in), .load_comp_in(load_comp_in),
      .charger_detect_in(charger_detect_in), .wake_pin_n(wake_pin_n),
      .irq_out_n(irq_out_n), .host_clear_out_n(host_clear_out_n),
      .delay_cap_charge(delay_cap_charge), .fet_clear(fet_clear),
      .load_pulldown_en(load_pulldown_en), .charger_pullup_en(charger_pullup_en),
      .measure_en(measure_en), .power_save_state(power_save_state));
   slp_host_model host (.clk(clk), .rdata(rdata), .host_clear_out_n(host_clear_out_n),
      .req(req));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(negedge clk) if (fet_clear === 1'b1) n_fet++;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask

   task automatic summarize();
      if (n_mismatch == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      host.rd(SA, v); chk(v, slp_pkg::REG_RESET, "sense reset");
      host.rd(PA, v); chk(v, slp_pkg::REG_RESET, "power reset");
      host.rd(8'h07, v); chk(v, slp_pkg::UNMAPPED_READ, "unmapped");
      chk(irq_out_n, 8'h01, "irq idle");
      chk(host_clear_out_n, 8'h01, "host clear idle");
      host.wr(SA, 8'h73); host.rd(SA, v); chk(v, 8'h40, "ro bits");
      host.wr(PA, 8'h81); host.rd(PA, v); chk(v, 8'h01, "save bit");
      host.wr(PA, 8'h00);
      host.wr(SA, 8'h00);
   endtask

   task automatic t_short();
      short_comp_in = 1'b1;
      cyc(DLY + 4);
      chk(delay_cap_charge, 8'h00, "charge while off");
      host.rd(SA, v); chk(v, 8'h00, "comp while off");
      short_comp_in = 1'b0;
      host.wr(SA, 8'hc0);
      f0 = n_fet;
      short_comp_in = 1'b1;
      cyc(DLY / 2);
      chk(delay_cap_charge, 8'h01, "charge start");
      short_comp_in = 1'b0;
      cyc(3);
      chk(delay_cap_charge, 8'h00, "charge abort");
      host.rd(SA, v); chk(v, 8'hc0, "abort no flag");
      chk(8'(n_fet - f0), 8'h00, "abort no fet");
      short_comp_in = 1'b1;
      n = 0;
      while (fet_clear !== 1'b1 && n < DLY + 10)
      begin
         cyc(1);
         n++;
      end
      chk({7'h00, n >= DLY - 1 && n <= DLY + 1}, 8'h01, "delay length");
      cyc(2);
      chk(irq_out_n, 8'h00, "short irq");
      host.rd(SA, v); chk(v, 8'hf0, "short flag");
      cyc(DLY + 2);
      chk(8'(n_fet - f0), 8'h01, "one trip");
      short_comp_in = 1'b0;
      host.wr(SA, 8'he0); host.rd(SA, v); chk(v, 8'he0, "flag kept");
      host.wr(SA, 8'hc0); host.rd(SA, v); chk(v, 8'hc0, "flag clear");
      chk(irq_out_n, 8'h01, "irq released");
      host.wr(SA, 8'h80);
      short_comp_in = 1'b1;
      cyc(DLY + 4);
      chk(8'(n_fet - f0), 8'h02, "trip no irq");
      host.rd(SA, v); chk(v, 8'h90, "flag forced");
      chk(irq_out_n, 8'h01, "irq masked");
      short_comp_in = 1'b0;
      host.wr(SA, 8'h00); // FET bits are rewritten by the host elsewhere
   endtask

   task automatic t_load();
      load_comp_in = 1'b1;
      cyc(3);
      host.rd(SA, v); chk(v, 8'h00, "load off");
      chk(load_pulldown_en, 8'h00, "pulldown off");
      load_comp_in = 1'b0;
      host.enable_load_irq();
      chk(load_pulldown_en, 8'h01, "pulldown on");
      load_comp_in = 1'b1;
      cyc(4);
      host.rd(SA, v); chk(v, 8'h0f, "load flag");
      chk(irq_out_n, 8'h00, "load irq");
      host.wr(SA, 8'h0e); host.rd(SA, v); chk(v, 8'h0f, "flag kept");
      host.wr(SA, 8'h08); host.rd(SA, v); chk(v, 8'h09, "flag forced");
      chk(irq_out_n, 8'h01, "irq off");
      load_comp_in = 1'b0;
      host.wr(SA, 8'h08);
      host.wr(PA, 8'h01);
      cyc(2);
      chk(measure_en, 8'h00, "save stops");
      chk(power_save_state, 8'h01, "save state");
      load_comp_in = 1'b1;
      cyc(3);
      host.rd(SA, v); chk(v, 8'h00, "comp stopped");
      load_comp_in = 1'b0;
      host.wr(PA, 8'h00);
      cyc(2);
      chk(measure_en, 8'h01, "back to run");
      host.wr(SA, 8'h08); // load comparator comes back by hand
      cyc(1);
      chk(load_pulldown_en, 8'h01, "re-enabled");
      host.wr(SA, 8'h00);
   endtask

   task automatic t_down();
      host.wr(SA, 8'hc8);
      wake_pin_n = 1'b0;
      host.rd(PA, v); chk(v, 8'h80, "wake low seen");
      host.wr(PA, 8'h10);
      cyc(6);
      chk(host_clear_out_n, 8'h01, "deferred");
      chk(measure_en, 8'h01, "still running");
      wake_pin_n = 1'b1;
      cyc(3);
      chk(host_clear_out_n, 8'h00, "down clear");
      chk(charger_pullup_en, 8'h01, "down pullup");
      chk(measure_en, 8'h00, "down stop");
      chk(load_pulldown_en, 8'h00, "down load");
      charger_detect_in = 1'b1;
      host.wait_release(n);
      charger_detect_in = 1'b0;
      chk({7'h00, n < 10}, 8'h01, "charger wakes");
      host.rd(SA, v); chk(v, 8'h00, "sense cleared");
      host.rd(PA, v); chk(v, 8'h00, "power cleared");
      host.wr(SA, 8'h44);
      host.power_down(v);
      chk(v, 8'h00, "pin high first");
      cyc(3);
      chk(host_clear_out_n, 8'h00, "down again");
      wake_pin_n = 1'b0;
      host.wait_release(n);
      chk({7'h00, n < 10}, 8'h01, "pin wakes");
      host.rd(PA, v); chk(v, 8'h80, "pin level");
      wake_pin_n = 1'b1;
      host.rd(SA, v); chk(v, 8'h00, "sense cleared");
   endtask

   initial
   begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      summarize();
   end

   initial
   begin
      sys_rst = 1'b1;
      short_comp_in = 1'b0;
      load_comp_in = 1'b0;
      charger_detect_in = 1'b0;
      wake_pin_n = 1'b1;
      cyc(5);
      sys_rst = 1'b0;
      t_reset();
      t_short();
      t_load();
      t_down();
      summarize();
   end
endmodule
